// file: hbm_meter.sv
`timescale 1ns/1ns
module hbm_meter
	import hbm_pkg::*;
#(
	parameter int FRAME_RATE_HZ = 50
) (
	input  wire logic                     clock_i,
	input  wire logic                     rst_i,
	input  wire logic                     pix_valid_i,
	input  wire logic                     frame_start_i,
	input  wire logic                     pix_last_i,
	input  wire logic                     curve_pq_i,
	input  wire logic                     luma_mode_i,
	input  wire logic [hbm_pkg::CODE_W-1:0] comp_r_i,
	input  wire logic [hbm_pkg::CODE_W-1:0] comp_g_i,
	input  wire logic [hbm_pkg::CODE_W-1:0] comp_b_i,
	input  wire logic [hbm_pkg::CODE_W-1:0] luma_i,
	output logic [hbm_pkg::LIN_W-1:0]        mean_luma_o,
	output logic signed [hbm_pkg::LVL_W-1:0] image_level_o,
	output logic signed [hbm_pkg::LVL_W-1:0] temporal_image_level_o,
	output logic [hbm_pkg::RESP_W-1:0]       image_level_response_o,
	output logic                             levels_valid_o,
	output logic                             busy_o
);
	import hbm_pkg::*;

	localparam int NLANE = 3;
	// Blend weights 24/(NUM*f+24) in Q16, rounded.
	localparam int UP_DEN = DECAY_DEN + DECAY_UP_NUM * FRAME_RATE_HZ;
	localparam int DN_DEN = DECAY_DEN + DECAY_DN_NUM * FRAME_RATE_HZ;
	localparam logic [16:0] ALPHA_UP = 17'((ONE_Q16 * DECAY_DEN + UP_DEN / 2) / UP_DEN);
	localparam logic [16:0] ALPHA_DN = 17'((ONE_Q16 * DECAY_DEN + DN_DEN / 2) / DN_DEN);

	// Linear interpolation inside one table segment.
	function automatic logic [LIN_W-1:0] interp(input logic [LIN_W-1:0] lo, input logic [LIN_W-1:0] hi,
		input logic [FRAC_W-1:0] fr);
		logic [LIN_W+FRAC_W-1:0] part;
		part = (LIN_W+FRAC_W)'(hi - lo) * (LIN_W+FRAC_W)'(fr);
		return lo + part[LIN_W+FRAC_W-1:FRAC_W];
	endfunction

	// Position of the highest set bit, zero for an empty word.
	function automatic logic [5:0] msb_index(input logic [SUM_W-1:0] v);
		logic [5:0] m;
		m = '0;
		for (int i = 0; i < SUM_W; i++) begin
			if (v[i]) begin
				m = 6'(i);
			end
		end
		return m;
	endfunction

	logic [CODE_W-1:0] code_w [NLANE];     // Code per lane.
	logic [LIN_W-1:0]  lo_w [NLANE];       // Segment starts from the tables.
	logic [LIN_W-1:0]  hi_w [NLANE];       // Segment ends from the tables.
	logic [FRAC_W-1:0] s1_frac_reg [NLANE]; // Fraction waiting for the table.
	logic              s1_valid_reg, s1_start_reg, s1_last_reg, s1_luma_reg;
	logic [LIN_W-1:0]  s2_lin_reg [NLANE]; // Linear light per component.
	logic              s2_valid_reg, s2_start_reg, s2_last_reg, s2_luma_reg;
	logic [LIN_W-1:0]  y_reg;              // Pixel luminance.
	logic              s3_valid_reg, s3_start_reg, s3_last_reg;
	logic [SUM_W-1:0]  acc_reg;            // Running luminance sum.
	logic [CNT_W-1:0]  cnt_reg;            // Running pixel count.
	logic              done_reg;           // Frame totals are complete.

	// Lane zero carries the single luma or intensity code in luma mode.
	always_comb begin
		code_w[0] = luma_mode_i ? luma_i : comp_r_i;
		code_w[1] = comp_g_i;
		code_w[2] = comp_b_i;
	end

	hbm_lut_if lut [NLANE] ();

	for (genvar gi = 0; gi < NLANE; gi++) begin : g_lane
		assign lut[gi].idx = code_w[gi][CODE_W-1 -: IDX_W];
		assign lut[gi].curve = curve_pq_i;
		assign lo_w[gi] = lut[gi].lo;
		assign hi_w[gi] = lut[gi].hi;
		hbm_eotf_rom u_rom (
			.clock_i (clock_i),
			.rst_i   (rst_i),
			.port    (lut[gi].rom)
		);
	end

	// Pixel pipeline: table read, interpolation, weighting; flags ride along.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{s1_valid_reg, s1_start_reg, s1_last_reg, s1_luma_reg} <= '0;
			{s2_valid_reg, s2_start_reg, s2_last_reg, s2_luma_reg} <= '0;
			{s3_valid_reg, s3_start_reg, s3_last_reg} <= '0;
			y_reg <= '0;
			for (int i = 0; i < NLANE; i++) begin
				s1_frac_reg[i] <= '0;
				s2_lin_reg[i] <= '0;
			end
		end else begin
			s1_valid_reg <= pix_valid_i;
			s1_start_reg <= pix_valid_i & frame_start_i;
			s1_last_reg <= pix_valid_i & pix_last_i;
			s1_luma_reg <= luma_mode_i;
			{s2_valid_reg, s2_start_reg, s2_last_reg, s2_luma_reg} <=
				{s1_valid_reg, s1_start_reg, s1_last_reg, s1_luma_reg};
			{s3_valid_reg, s3_start_reg, s3_last_reg} <= {s2_valid_reg, s2_start_reg, s2_last_reg};
			for (int i = 0; i < NLANE; i++) begin
				s1_frac_reg[i] <= code_w[i][FRAC_W-1:0];
				s2_lin_reg[i] <= interp(lo_w[i], hi_w[i], s1_frac_reg[i]);
			end
			// The luma path bypasses weighting; everything later is shared.
			if (s2_luma_reg) begin
				y_reg <= s2_lin_reg[0];
			end else begin
				y_reg <= LIN_W'((39'(s2_lin_reg[0]) * 39'(W_RED) + 39'(s2_lin_reg[1]) * 39'(W_GREEN)
					+ 39'(s2_lin_reg[2]) * 39'(W_BLUE)) >> W_SHIFT);
			end
		end
	end

	// Frame accumulation; the start pixel reloads so no clear pulse is needed.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			acc_reg <= '0;
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= s3_valid_reg & s3_last_reg;
			if (s3_valid_reg) begin
				acc_reg <= (s3_start_reg ? '0 : acc_reg) + SUM_W'(y_reg);
				cnt_reg <= (s3_start_reg ? '0 : cnt_reg) + CNT_W'(1);
			end
		end
	end

	hbm_state_t state_reg;                  // Per-frame sequencer.
	logic [5:0]  step_reg;                  // Divider or logarithm step.
	logic [SUM_W:0]   rem_reg;              // Divider remainder.
	logic [SUM_W-1:0] quo_reg;              // Dividend shifting into quotient.
	logic [SUM_W-1:0] den_reg;              // Divisor.
	logic [15:0] lx_reg;                    // Mantissa in Q1.15 for the logarithm.
	logic signed [LVL_W-1:0] lg_reg;        // Image level being built.
	logic signed [LVL_W-1:0] adapt_reg;     // Temporal level.
	logic [LIN_W-1:0]  mean_reg;            // Frame mean.
	logic [RESP_W-1:0] resp_reg;            // Response.
	logic first_reg;                        // No frame has been filtered yet.

	logic [SUM_W:0] rem_sh, rem_nx;
	logic [SUM_W-1:0] quo_nx;
	logic fits;
	logic [31:0] sq;
	logic [5:0] msb_w;
	logic signed [LVL_W:0] diff_w;
	logic [16:0] alpha_w;
	logic signed [LVL_W+18:0] blend_w;
	logic signed [38:0] dprod_w;
	logic signed [23:0] d_w;
	logic [11:0] fr_w;
	logic [23:0] quad_w;
	logic [12:0] pf_w;
	logic [SUM_W-1:0] e_w;
	logic signed [5:0] di_w;

	// Shared datapath: one restoring division step, one squaring step,
	// the blend and the exponential, all feeding the sequencer.
	always_comb begin
		rem_sh = {rem_reg[SUM_W-1:0], quo_reg[SUM_W-1]};
		fits = rem_sh >= {1'b0, den_reg};
		rem_nx = fits ? rem_sh - {1'b0, den_reg} : rem_sh;
		quo_nx = {quo_reg[SUM_W-2:0], fits};
		sq = 32'(lx_reg) * 32'(lx_reg);
		msb_w = msb_index(quo_nx);
		diff_w = (LVL_W+1)'(lg_reg) - (LVL_W+1)'(adapt_reg);
		alpha_w = (diff_w >= 0) ? ALPHA_UP : ALPHA_DN;
		blend_w = (LVL_W+19)'(diff_w) * $signed({1'b0, alpha_w});
		dprod_w = 39'((LVL_W+1)'(adapt_reg) - (LVL_W+1)'(lg_reg)) * $signed({1'b0, NC_Q16});
		d_w = 24'(dprod_w >>> 16);
		fr_w = d_w[11:0];
		di_w = 6'(d_w >>> LVL_FRAC);
		quad_w = 24'(fr_w) * 24'(24'(EXP_C1) + ((24'(EXP_C2) * 24'(fr_w)) >> LVL_FRAC));
		pf_w = EXP_ONE + 13'(quad_w >> LVL_FRAC);
		e_w = (di_w >= 0) ? SUM_W'(pf_w) << di_w : SUM_W'(pf_w) >> (-di_w);
	end

	// Sequencer: mean, log2, temporal filter, response, then publish.
	// A frame that ends while a previous one is still being processed is
	// skipped; with 48-step divisions this needs frames of at least 112 pixels.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			step_reg <= '0;
			rem_reg <= '0;
			quo_reg <= '0;
			den_reg <= '0;
			lx_reg <= '0;
			lg_reg <= '0;
			adapt_reg <= '0;
			mean_reg <= '0;
			resp_reg <= '0;
			first_reg <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (done_reg) begin
						rem_reg <= '0;
						quo_reg <= acc_reg;
						den_reg <= SUM_W'(cnt_reg);
						step_reg <= '0;
						state_reg <= ST_MEAN;
					end
				end
				ST_MEAN: begin
					rem_reg <= rem_nx;
					quo_reg <= quo_nx;
					step_reg <= step_reg + 6'd1;
					if (step_reg == DIV_LAST) begin
						mean_reg <= LIN_W'(quo_nx);
						step_reg <= '0;
						lx_reg <= 16'((quo_nx << (6'(SUM_W-1) - msb_w)) >> (SUM_W-16));
						// Integer part first; fraction bits shift in below it.
						lg_reg <= LVL_W'(signed'({1'b0, msb_w}) - 7'sd8);
						state_reg <= ST_LOG;
						if (quo_nx == '0) begin
							lg_reg <= {1'b1, {(LVL_W-1){1'b0}}};
							state_reg <= ST_FILT;
						end
					end
				end
				ST_LOG: begin
					// Squaring the mantissa doubles the log; overflow is the next bit.
					lg_reg <= {lg_reg[LVL_W-2:0], sq[31]};
					lx_reg <= sq[31] ? sq[31:16] : sq[30:15];
					step_reg <= step_reg + 6'd1;
					if (step_reg[3:0] == LOG_LAST) begin
						state_reg <= ST_FILT;
					end
				end
				ST_FILT: begin
					first_reg <= 1'b0;
					if (first_reg) begin
						adapt_reg <= lg_reg;
					end else begin
						adapt_reg <= adapt_reg + LVL_W'(blend_w >>> 16);
					end
					state_reg <= ST_EXP;
				end
				ST_EXP: begin
					// B/A = 2^(0.57*(temporal - level)); response = 1/(1 + B/A).
					rem_reg <= '0;
					quo_reg <= RESP_NUM;
					den_reg <= SUM_W'(EXP_ONE) + e_w;
					step_reg <= '0;
					state_reg <= ST_RESP;
					if (d_w >= EXP_LIM) begin
						resp_reg <= '0;
						state_reg <= ST_PUB;
					end else if (d_w <= -EXP_LIM) begin
						resp_reg <= RESP_MAX;
						state_reg <= ST_PUB;
					end
				end
				ST_RESP: begin
					rem_reg <= rem_nx;
					quo_reg <= quo_nx;
					step_reg <= step_reg + 6'd1;
					if (step_reg == DIV_LAST) begin
						resp_reg <= (quo_nx > SUM_W'(RESP_MAX)) ? RESP_MAX : RESP_W'(quo_nx);
						state_reg <= ST_PUB;
					end
				end
				ST_PUB: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// All results change together, in the cycle of the valid pulse.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			mean_luma_o <= '0;
			image_level_o <= '0;
			temporal_image_level_o <= '0;
			image_level_response_o <= '0;
			levels_valid_o <= 1'b0;
		end else begin
			levels_valid_o <= (state_reg == ST_PUB);
			if (state_reg == ST_PUB) begin
				mean_luma_o <= mean_reg;
				image_level_o <= lg_reg;
				temporal_image_level_o <= adapt_reg;
				image_level_response_o <= resp_reg;
			end
		end
	end

	assign busy_o = (state_reg != ST_IDLE);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	luma_weight_a: assert property (s2_valid_reg && !s2_luma_reg && s2_lin_reg[0] == s2_lin_reg[1]
		&& s2_lin_reg[1] == s2_lin_reg[2] |=> y_reg == $past(s2_lin_reg[0]))
		else $error("Grey pixel luminance differs from its components.");
	luma_path_a: assert property (s2_valid_reg && s2_luma_reg |=> y_reg == $past(s2_lin_reg[0]))
		else $error("Luma mode value not passed to averaging.");
	mean_div_a: assert property (state_reg == ST_MEAN && step_reg == DIV_LAST |-> rem_nx < {1'b0, den_reg})
		else $error("Mean division left a remainder above the count.");
	unity_level_a: assert property (state_reg == ST_MEAN && step_reg == DIV_LAST && quo_nx == SUM_W'(ONE_Q8)
		|-> ##13 (state_reg == ST_FILT && lg_reg == 0))
		else $error("Unit mean did not give level zero.");
	first_frame_a: assert property (state_reg == ST_FILT && first_reg |=> adapt_reg == $past(lg_reg))
		else $error("First frame temporal level not copied.");
	blend_range_a: assert property (state_reg == ST_FILT && !first_reg && lg_reg >= adapt_reg
		|=> adapt_reg >= $past(adapt_reg) && adapt_reg <= $past(lg_reg))
		else $error("Temporal level left the blend interval.");
	decay_pick_a: assert property (state_reg == ST_FILT && !first_reg && lg_reg < adapt_reg |-> alpha_w == ALPHA_DN)
		else $error("Falling level did not use the long decay.");
	response_half_a: assert property (state_reg == ST_EXP && adapt_reg == lg_reg
		|-> ##49 (state_reg == ST_PUB && resp_reg == 16'h8000))
		else $error("Equal levels did not give half response.");
	publish_once_a: assert property (levels_valid_o |=> !levels_valid_o && image_level_o == $past(image_level_o))
		else $error("Results not published as a single pulse.");
endmodule // hbm_meter

// file: hbm_pkg.sv
package hbm_pkg;
	// Sample code and lookup geometry.
	localparam int CODE_W   = 10;
	localparam int IDX_W    = 4;
	localparam int FRAC_W   = 6;
	localparam int LUT_LAST = 15;
	// Linear light carries 8 fraction bits, so 256 means 1 cd/m2.
	localparam int LIN_W    = 22;
	localparam int LIN_FRAC = 8;
	localparam logic [LIN_W-1:0] ONE_Q8 = 22'h000100;
	localparam logic [LIN_W-1:0] HLG_PEAK_Q8 = 22'h03E800;
	localparam logic [LIN_W-1:0] PQ_PEAK_Q8  = 22'h271000;
	// The tables bake in a display system gamma of 1.2 (stored times ten).
	localparam int SYS_GAMMA_X10 = 12;
	// Frame accumulator and pixel counter.
	localparam int SUM_W = 48;
	localparam int CNT_W = 24;
	// Luminance weights in Q16; they sum to exactly 65536.
	localparam logic [16:0] W_RED   = 17'h04341;
	localparam logic [16:0] W_GREEN = 17'h0AD91;
	localparam logic [16:0] W_BLUE  = 17'h00F2E;
	localparam int W_SHIFT = 16;
	// Levels are signed with 12 fraction bits; response is Q0.16.
	localparam int LVL_W    = 20;
	localparam int LVL_FRAC = 12;
	localparam int RESP_W   = 16;
	localparam logic [RESP_W-1:0] RESP_MAX = 16'hFFFF;
	// Eye exponent 0.57 in Q16.
	localparam logic [16:0] NC_Q16 = 17'h091EC;
	// Decay time is NUM*f/DEN frames; up for brightening, down for darkening.
	localparam int DECAY_UP_NUM = 22;
	localparam int DECAY_DN_NUM = 800;
	localparam int DECAY_DEN    = 24;
	localparam int ONE_Q16      = 65536;
	// Second-order fit of 2^x on [0,1) in Q12: 1 + x*(C1 + C2*x).
	localparam logic [12:0] EXP_ONE = 13'h1000;
	localparam logic [11:0] EXP_C1  = 12'hA81;
	localparam logic [11:0] EXP_C2  = 12'h57F;
	// Exponent magnitude beyond which the response is saturated.
	localparam logic signed [23:0] EXP_LIM = 24'sh010000;
	// Response numerator 2^28 gives a Q16 quotient over a Q12 divisor.
	localparam logic [SUM_W-1:0] RESP_NUM = 48'h000010000000;
	localparam logic [5:0] DIV_LAST = 6'h2F;
	localparam logic [3:0] LOG_LAST = 4'hB;
	typedef enum {ST_IDLE, ST_MEAN, ST_LOG, ST_FILT, ST_EXP, ST_RESP, ST_PUB} hbm_state_t;
endpackage

// file: hbm_lut_if.sv
`timescale 1ns/1ns
// One lookup lane: segment index and curve out, the two segment ends back.
interface hbm_lut_if;
	import hbm_pkg::*;
	logic [IDX_W-1:0] idx;   // Upper code bits select the segment.
	logic             curve; // High selects the perceptual quantizer curve.
	logic [LIN_W-1:0] lo;    // Segment start, registered.
	logic [LIN_W-1:0] hi;    // Segment end, registered.
	modport requester (output idx, output curve, input lo, input hi);
	modport rom (input idx, input curve, output lo, output hi);
endinterface

// file: hbm_eotf_rom.sv
`timescale 1ns/1ns
module hbm_eotf_rom
	import hbm_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic rst_i,
	hbm_lut_if.rom    port
);
	// Seventeen breakpoints per curve in cd/m2 Q8; the segment between
	// neighbours is interpolated linearly by the caller, which costs some
	// accuracy in the steep top segments of the quantizer curve.
	function automatic logic [LIN_W-1:0] point(input logic pq, input logic [4:0] k);
		logic [LIN_W-1:0] v;
		v = '0;
		if (pq) begin
			case (k)
				5'd1: v = 22'd26;       5'd2: v = 22'd152;      5'd3: v = 22'd504;
				5'd4: v = 22'd1321;     5'd5: v = 22'd3008;     5'd6: v = 22'd6298;
				5'd7: v = 22'd12416;    5'd8: v = 22'd23629;    5'd9: v = 22'd43520;
				5'd10: v = 22'd79104;   5'd11: v = 22'd141568;  5'd12: v = 22'd251904;
				5'd13: v = 22'd446720;  5'd14: v = 22'd792832;  5'd15: v = 22'd1415424;
				5'd16: v = PQ_PEAK_Q8;
				default: v = '0;
			endcase
		end else begin
			case (k)
				5'd1: v = 22'd88;       5'd2: v = 22'd466;      5'd3: v = 22'd1234;
				5'd4: v = 22'd2458;     5'd5: v = 22'd4198;     5'd6: v = 22'd6502;
				5'd7: v = 22'd9421;     5'd8: v = 22'd12979;    5'd9: v = 22'd17766;
				5'd10: v = 22'd24934;   5'd11: v = 22'd35738;   5'd12: v = 22'd51968;
				5'd13: v = 22'd76544;   5'd14: v = 22'd113920;  5'd15: v = 22'd170240;
				5'd16: v = HLG_PEAK_Q8;
				default: v = '0;
			endcase
		end
		return v;
	endfunction

	// Both segment ends are read in one cycle so each lane interpolates per pixel.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			port.lo <= '0;
			port.hi <= '0;
		end else begin
			port.lo <= point(port.curve, {1'b0, port.idx});
			port.hi <= point(port.curve, 5'({1'b0, port.idx}) + 5'd1);
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	hlg_peak_a: assert property (!port.curve && port.idx == IDX_W'(LUT_LAST) |=> port.hi == HLG_PEAK_Q8)
		else $error("HLG top segment does not end at peak.");
	pq_peak_a: assert property (port.curve && port.idx == IDX_W'(LUT_LAST) |=> port.hi == PQ_PEAK_Q8)
		else $error("PQ top segment does not end at peak.");
endmodule // hbm_eotf_rom

// file: hbm_src_model.sv
`timescale 1ns/1ns
// Video source stand-in: sends whole frames, at times with idle gaps between pixels.
module hbm_src_model
	import hbm_pkg::*;
(
	input  wire logic                  clock_i,
	output logic                       pix_valid_o,
	output logic                       frame_start_o,
	output logic                       pix_last_o,
	output logic                       curve_pq_o,
	output logic                       luma_mode_o,
	output logic [hbm_pkg::CODE_W-1:0] comp_r_o,
	output logic [hbm_pkg::CODE_W-1:0] comp_g_o,
	output logic [hbm_pkg::CODE_W-1:0] comp_b_o,
	output logic [hbm_pkg::CODE_W-1:0] luma_o
);
	logic [31:0] seed = 32'h7B004C0D; // Random state; the fixed start keeps runs repeatable.

	// Feedback step of the shift register.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Lines are quiet before the first frame.
	initial begin
		{pix_valid_o, frame_start_o, pix_last_o, curve_pq_o, luma_mode_o} = 5'h00;
		{comp_r_o, comp_g_o, comp_b_o, luma_o} = 40'h0;
	end

	// Idle cycle; data is inverted so a stale value never passes for a real one.
	task automatic idle();
		@(posedge clock_i);
		pix_valid_o   <= 1'b0;
		frame_start_o <= 1'b0;
		pix_last_o    <= 1'b0;
		comp_r_o      <= ~comp_r_o;
		comp_g_o      <= ~comp_g_o;
		comp_b_o      <= ~comp_b_o;
		luma_o        <= ~luma_o;
	endtask

	// One frame: first half code a, second half code b, or random codes; msk picks R, G, B.
	task automatic send_frame(input logic pq, input logic lm, input int n, input logic [CODE_W-1:0] a,
			input logic [CODE_W-1:0] b, input logic rnd, input logic [2:0] msk);
		logic [CODE_W-1:0] c;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			// A random gap makes the source slow at times.
			if (seed[3]) begin
				idle();
			end
			c = (i < n / 2) ? a : b;
			@(posedge clock_i);
			pix_valid_o   <= 1'b1;
			frame_start_o <= (i == 0);
			pix_last_o    <= (i == n - 1);
			curve_pq_o    <= pq;
			luma_mode_o   <= lm;
			comp_r_o      <= msk[2] ? (rnd ? seed[9:0] : c) : 10'h000;
			comp_g_o      <= msk[1] ? (rnd ? seed[19:10] : c) : 10'h000;
			comp_b_o      <= msk[0] ? (rnd ? seed[29:20] : c) : 10'h000;
			luma_o        <= rnd ? seed[15:6] : c;
		end
		idle();
	endtask
endmodule // hbm_src_model

// file: hbm_meter_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the per-frame brightness meter.
module hbm_meter_tb;
	import hbm_pkg::*;
	localparam int FR = 50; // Frame rate handed to the meter.
	logic                    clock_i = 1'b0; // 50 MHz.
	logic                    rst_i = 1'b1;   // Held for 16 cycles at start.
	logic                    pv, fs, pl, pq, lm;
	logic [CODE_W-1:0]       cr, cg, cb, cy;
	logic [LIN_W-1:0]        mean;
	logic signed [LVL_W-1:0] img_lvl, adapt_lvl;
	logic [RESP_W-1:0]       resp;
	logic                    lv, busy;
	int                      fail_count = 0;
	int                      checks = 0;
	logic signed [31:0]      prev_adapt = 32'sh0; // Temporal level of the frame before.
	logic [LIN_W-1:0]        m_top, m_mid;       // Earlier means reused for relative checks.
	real                     wt[3] = '{0.2627, 0.6780, 0.0593};

	always #10 clock_i = ~clock_i;

	hbm_src_model src (.clock_i(clock_i), .pix_valid_o(pv), .frame_start_o(fs), .pix_last_o(pl),
		.curve_pq_o(pq), .luma_mode_o(lm), .comp_r_o(cr), .comp_g_o(cg), .comp_b_o(cb), .luma_o(cy));

	hbm_meter #(.FRAME_RATE_HZ(FR)) DUT (.clock_i(clock_i), .rst_i(rst_i), .pix_valid_i(pv),
		.frame_start_i(fs), .pix_last_i(pl), .curve_pq_i(pq), .luma_mode_i(lm), .comp_r_i(cr),
		.comp_g_i(cg), .comp_b_i(cb), .luma_i(cy), .mean_luma_o(mean), .image_level_o(img_lvl),
		.temporal_image_level_o(adapt_lvl), .image_level_response_o(resp), .levels_valid_o(lv), .busy_o(busy));

	// One comparison; the tolerance covers the table-based curves, and unknowns never match.
	task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp, input int tol);
		checks++;
		if ((seen ^ seen) !== 32'h0 || seen - exp > tol || exp - seen > tol) begin
			fail_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Closing report and verdict.
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Level in Q12 from a Q8 mean; a zero mean pins the most negative code.
	function automatic int exp_level(input real m);
		if (m == 0.0) begin
			return -524288;
		end
		return int'($floor($ln(m / 256.0) / $ln(2.0) * 4096.0));
	endfunction

	// Recursive blend; slow decay when the picture darkens.
	function automatic int exp_adapt(input int prev, input int cur, input logic first);
		real tau;
		if (first) begin
			return cur;
		end
		tau = ((cur - prev) >= 0 ? 22.0 : 800.0) * FR / 24.0;
		return int'(prev + (cur - prev) / (tau + 1.0));
	endfunction

	// Eye response in Q0.16, clamped to the output range.
	function automatic int exp_resp(input int lvl, input int tl);
		real r;
		r = 65536.0 / (1.0 + 2.0 ** (0.57 * (tl - lvl) / 4096.0));
		return (r > 65535.0) ? 65535 : int'(r);
	endfunction

	// Sends a frame, waits for its pulse under a bound and checks the results together.
	task automatic frame(input logic p, input logic l, input logic [CODE_W-1:0] a,
			input logic [CODE_W-1:0] b, input logic r, input logic [2:0] msk, input logic first);
		int k;
		logic signed [31:0] lvl_s, adapt_s;
		src.send_frame(p, l, 128, a, b, r, msk);
		k = 0;
		while (lv !== 1'b1 && k < 400) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		check(lv, 1, 0);
		lvl_s = img_lvl;
		adapt_s = adapt_lvl;
		check(lvl_s, exp_level(real'(mean)), 2);
		check(adapt_s, exp_adapt(prev_adapt, lvl_s, first), 4);
		check(resp, exp_resp(lvl_s, adapt_s), 700);
		prev_adapt = adapt_s;
		@(posedge clock_i);
		#1;
		check(lv, 0, 0);
	endtask

	// Main sequence: corner frames first, then random ones, then a reset in mid-run.
	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		check({lv, busy, resp}, 0, 0);
		frame(1'b0, 1'b0, 10'h000, 10'h000, 1'b0, 3'b111, 1'b1);
		check(mean, 0, 0);
		frame(1'b0, 1'b0, 10'h3FF, 10'h3FF, 1'b0, 3'b111, 1'b0);
		check(mean <= HLG_PEAK_Q8 && mean > 22'h038400, 1, 0);
		frame(1'b1, 1'b0, 10'h3FF, 10'h3FF, 1'b0, 3'b111, 1'b0);
		m_top = mean;
		check(mean <= PQ_PEAK_Q8 && mean > 22'h232800, 1, 0);
		// Single colours expose each weight on its own.
		for (int c = 0; c < 3; c++) begin
			frame(1'b1, 1'b0, 10'h3FF, 10'h3FF, 1'b0, 3'b100 >> c, 1'b0);
			check(mean, int'(real'(m_top) * wt[c]), m_top / 16384);
		end
		frame(1'b1, 1'b0, 10'h0C8, 10'h0C8, 1'b0, 3'b111, 1'b0);
		m_mid = mean;
		frame(1'b1, 1'b1, 10'h0C8, 10'h0C8, 1'b0, 3'b000, 1'b0);
		check(mean, m_mid, 1);
		frame(1'b1, 1'b0, 10'h3FF, 10'h000, 1'b0, 3'b111, 1'b0);
		check(mean, m_top / 2, 2);
		// Two codes picked so the frame mean lands on one unit; the level must then read zero.
		frame(1'b1, 1'b0, 10'h080, 10'h0A6, 1'b0, 3'b111, 1'b0);
		check(img_lvl == 0, mean == ONE_Q8, 0);
		// Random codes, curves and modes.
		for (int i = 0; i < 4; i++) begin
			frame(src.seed[4], src.seed[5], 10'h000, 10'h000, 1'b1, 3'b111, 1'b0);
		end
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		// The response, busy and the pulse must come back quiet after a reset in mid-run.
		check({lv, busy, resp}, 0, 0);
		frame(1'b0, 1'b0, 10'h200, 10'h200, 1'b0, 3'b111, 1'b1);
		end_of_test();
	end

	// Several times the expected run length; a hang ends as a failure.
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		end_of_test();
	end
endmodule // hbm_meter_tb
